// >>> logic/ppl_top.sv
// palette lookup with host registers and packed pixel unpacking
// Operation
// R1 - at 1 bpp a byte is eight pixels, bit 7 leftmost
// R2 - at 1 bpp the pixel picks entry 0 or 1, green only for mono
// R3 - at 2 bpp a byte is four pixels, leftmost in bits 7:6
// R4 - at 2 bpp the pixel picks entries 0 to 3, green only for mono
// R5 - at 4 bpp upper nibble is left pixel, lower nibble right
// R6 - at 4 bpp the pixel indexes all sixteen entries directly
// R7 - at 8 bpp bits 7:5 red, 4:2 green, 1:0 blue indices
// R8 - monochrome panels show only the green element as gray
// R9 - sixteen entries of 4-bit red, green, blue, host readable
// R10 - index register holds entry pointer 3:0 and select 5:4
// R11 - writing the entry pointer points the next access at red
// R12 - auto select walks red, green, blue then bumps the entry
// R13 - single colour select touches that element and bumps entry
// R14 - mono auto writes store only the third value in all three
// R15 - mono single select write copies to all three then bumps
// R16 - mono reads advance the pointer exactly as colour reads
// R17 - bank register holds red 5:4, green 3:2, blue 1:0
// R18 - elements are reached only through the data register
// R19 - at 1 bpp lower eight entries form four two-entry banks
// R20 - at 2 bpp each bank step adds four to the index
// R21 - at 4 bpp bank choices are ignored
// R22 - at 8 bpp red, green two banks of eight, blue four of four
// R23 - select 01 red, 10 green, 11 blue
// R24 - unused index and bank bits read zero and ignore writes
//
// Our own choice: strobed register access.
`default_nettype none
module ppl_top (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] pix_byte_i,
  input wire logic pix_byte_valid_i,
  output logic pix_byte_ready_o,
  output logic [3:0] pix_red_o,
  output logic [3:0] pix_green_o,
  output logic [3:0] pix_blue_o,
  output logic pix_valid_o,
  input wire logic pix_ready_i
);
  localparam int EW = ppl_pkg::ELEM_W;
  localparam int NE = ppl_pkg::ENTRIES;
  localparam int NC = ppl_pkg::COLOURS;

  // colour palette, one array per colour element
  logic [EW-1:0] pal_r [NC][NE];
  // host side pointers
  logic [3:0] entry_ptr_r;
  logic [1:0] csel_r;
  logic [1:0] comp_ptr_r;
  // bank choices and configuration
  logic [1:0] bank_red_r;
  logic [1:0] bank_green_r;
  logic [1:0] bank_blue_r;
  logic [1:0] bpp_r;
  logic mono_r;
  // read data and pixel output stage
  logic [7:0] rdata_r;
  logic [3:0] red_r;
  logic [3:0] green_r;
  logic [3:0] blue_r;
  logic out_valid_r;

  // decoded host accesses
  logic wr_index;
  logic wr_bank;
  logic wr_data;
  logic wr_cfg;
  logic rd_data;
  logic data_acc;
  logic [1:0] tgt_elem;
  logic last_comp;
  logic store_one;
  logic store_all;
  logic bump_entry;
  logic [7:0] rd_value;

  // pixel path wires
  logic [7:0] pix_code;
  logic pix_code_valid;
  logic take_pix;
  logic [3:0] idx_red;
  logic [3:0] idx_green;
  logic [3:0] idx_blue;

  // address decode; the master never issues read and write together
  assign wr_index = reg_wr_i && (reg_addr_i == ppl_pkg::ADDR_INDEX);
  assign wr_bank = reg_wr_i && (reg_addr_i == ppl_pkg::ADDR_BANK);
  assign wr_data = reg_wr_i && (reg_addr_i == ppl_pkg::ADDR_DATA); // R18
  assign wr_cfg = reg_wr_i && (reg_addr_i == ppl_pkg::ADDR_CONFIG);
  assign rd_data = reg_rd_i && (reg_addr_i == ppl_pkg::ADDR_DATA); // R18
  assign data_acc = wr_data || rd_data;

  // element reached by the next data access
  always_comb begin
    case (csel_r)
      ppl_pkg::CSEL_RED: tgt_elem = ppl_pkg::ELEM_RED; // R23
      ppl_pkg::CSEL_GREEN: tgt_elem = ppl_pkg::ELEM_GREEN; // R23
      ppl_pkg::CSEL_BLUE: tgt_elem = ppl_pkg::ELEM_BLUE; // R23
      default: tgt_elem = comp_ptr_r; // R12
    endcase
  end

  // auto select bumps only after blue; single select bumps every time
  assign last_comp = (comp_ptr_r == ppl_pkg::ELEM_BLUE);
  assign bump_entry = data_acc &&
    ((csel_r != ppl_pkg::CSEL_AUTO) || last_comp); // R12 R13 R16

  // mono writes land in all three elements, auto mode only on the third
  assign store_all = wr_data && mono_r &&
    ((csel_r != ppl_pkg::CSEL_AUTO) || last_comp); // R14 R15
  assign store_one = wr_data && !mono_r; // R13

  // entry pointer and select field; a pointer write restarts at red
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      entry_ptr_r <= ppl_pkg::ENTRY_RST;
      csel_r <= ppl_pkg::CSEL_RST;
    end else if (wr_index) begin
      entry_ptr_r <= reg_wdata_i[ppl_pkg::ENTRY_LSB +: ppl_pkg::ENTRY_W];
      csel_r <= reg_wdata_i[ppl_pkg::CSEL_LSB +: ppl_pkg::CSEL_W]; // R10
    end else if (bump_entry) begin
      entry_ptr_r <= entry_ptr_r + 4'h1; // R12 R13
    end
  end

  // component pointer walks red, green, blue in auto mode
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      comp_ptr_r <= ppl_pkg::ELEM_RED;
    end else if (wr_index) begin
      comp_ptr_r <= ppl_pkg::ELEM_RED; // R11
    end else if (data_acc && csel_r == ppl_pkg::CSEL_AUTO) begin
      if (last_comp) begin
        comp_ptr_r <= ppl_pkg::ELEM_RED; // R12
      end else begin
        comp_ptr_r <= comp_ptr_r + 2'h1; // R12 R16
      end
    end
  end

  // palette storage; mono copies the value into every element
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int c = 0; c < NC; c++) begin
        for (int e = 0; e < NE; e++) begin
          pal_r[c][e] <= ppl_pkg::ELEM_RST;
        end
      end
    end else if (store_all) begin
      for (int c = 0; c < NC; c++) begin
        pal_r[c][entry_ptr_r] <= reg_wdata_i[EW-1:0]; // R14 R15
      end
    end else if (store_one) begin
      pal_r[tgt_elem][entry_ptr_r] <= reg_wdata_i[EW-1:0]; // R9
    end
  end

  // bank choices steer display lookup only
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bank_red_r <= ppl_pkg::BANK_RST[ppl_pkg::BANK_RED_LSB +: 2];
      bank_green_r <= ppl_pkg::BANK_RST[ppl_pkg::BANK_GREEN_LSB +: 2];
      bank_blue_r <= ppl_pkg::BANK_RST[ppl_pkg::BANK_BLUE_LSB +: 2];
    end else if (wr_bank) begin
      bank_red_r <= reg_wdata_i[ppl_pkg::BANK_RED_LSB +: 2]; // R17
      bank_green_r <= reg_wdata_i[ppl_pkg::BANK_GREEN_LSB +: 2]; // R17
      bank_blue_r <= reg_wdata_i[ppl_pkg::BANK_BLUE_LSB +: 2]; // R17
    end
  end

  // depth and panel type; changing them mid-frame is the host's problem
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bpp_r <= ppl_pkg::BPP1;
      mono_r <= 1'b0;
    end else if (wr_cfg) begin
      bpp_r <= reg_wdata_i[ppl_pkg::CFG_BPP_LSB +: 2];
      mono_r <= reg_wdata_i[ppl_pkg::CFG_MONO_BIT];
    end
  end

  // read mux; unused bits and unmapped addresses read as zero
  always_comb begin
    case (reg_addr_i)
      ppl_pkg::ADDR_INDEX: rd_value = {2'b00, csel_r, entry_ptr_r}; // R24
      ppl_pkg::ADDR_BANK: rd_value = {2'b00, bank_red_r,
        bank_green_r, bank_blue_r}; // R24
      ppl_pkg::ADDR_DATA: rd_value = {4'h0,
        pal_r[tgt_elem][entry_ptr_r]}; // R9 R16
      ppl_pkg::ADDR_CONFIG: rd_value = {5'h00, mono_r, bpp_r};
      default: rd_value = ppl_pkg::RDATA_IDLE;
    endcase
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= ppl_pkg::RDATA_IDLE;
    end else if (reg_rd_i) begin
      rdata_r <= rd_value;
    end else begin
      rdata_r <= ppl_pkg::RDATA_IDLE;
    end
  end
  assign reg_rdata_o = rdata_r;

  // byte to pixel code unpacking
  ppl_unpack u_unpack (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .mode_i(bpp_r),
    .byte_i(pix_byte_i),
    .byte_valid_i(pix_byte_valid_i),
    .byte_ready_o(pix_byte_ready_o),
    .pix_o(pix_code),
    .pix_valid_o(pix_code_valid),
    .pix_ready_i(take_pix)
  );

  // pixel code to entry index per colour; this decode takes the live depth bpp_r,
  // not the depth that the unpacker latches with each byte
  ppl_bank u_bank (
    .mode_i(bpp_r),
    .pix_i(pix_code),
    .bank_red_i(bank_red_r),
    .bank_green_i(bank_green_r),
    .bank_blue_i(bank_blue_r),
    .idx_red_o(idx_red),
    .idx_green_o(idx_green),
    .idx_blue_o(idx_blue)
  );

  // one-stage output register; it stalls the unpacker when held
  assign take_pix = pix_code_valid && (!out_valid_r || pix_ready_i);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_valid_r <= 1'b0;
    end else if (take_pix) begin
      out_valid_r <= 1'b1;
    end else if (pix_ready_i) begin
      out_valid_r <= 1'b0;
    end
  end

  // colour lookup; mono panels drive the green element as gray
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      red_r <= ppl_pkg::ELEM_RST;
      green_r <= ppl_pkg::ELEM_RST;
      blue_r <= ppl_pkg::ELEM_RST;
    end else if (take_pix) begin
      green_r <= pal_r[ppl_pkg::ELEM_GREEN][idx_green];
      if (mono_r) begin
        red_r <= pal_r[ppl_pkg::ELEM_GREEN][idx_green]; // R8 R2 R4
        blue_r <= pal_r[ppl_pkg::ELEM_GREEN][idx_green]; // R8 R6
      end else begin
        red_r <= pal_r[ppl_pkg::ELEM_RED][idx_red]; // R2 R4 R6
        blue_r <= pal_r[ppl_pkg::ELEM_BLUE][idx_blue]; // R7
      end
    end
  end

  assign pix_red_o = red_r;
  assign pix_green_o = green_r;
  assign pix_blue_o = blue_r;
  assign pix_valid_o = out_valid_r;
endmodule
`default_nettype wire

// >>> logic/ppl_pkg.sv
// constants and types shared by the palette lookup block
`default_nettype none
package ppl_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_INDEX = 8'h15;
  localparam logic [7:0] ADDR_BANK = 8'h16;
  localparam logic [7:0] ADDR_DATA = 8'h17;
  localparam logic [7:0] ADDR_CONFIG = 8'h20;
  // palette index register fields
  localparam int ENTRY_LSB = 0;
  localparam int ENTRY_W = 4;
  localparam int CSEL_LSB = 4;
  localparam int CSEL_W = 2;
  // bank choice register fields
  localparam int BANK_BLUE_LSB = 0;
  localparam int BANK_GREEN_LSB = 2;
  localparam int BANK_RED_LSB = 4;
  localparam int BANK_W = 2;
  // configuration register fields
  localparam int CFG_BPP_LSB = 0;
  localparam int CFG_MONO_BIT = 2;
  // reset values
  localparam logic [3:0] ENTRY_RST = 4'h0;
  localparam logic [1:0] CSEL_RST = 2'h0;
  localparam logic [5:0] BANK_RST = 6'h00;
  localparam logic [3:0] ELEM_RST = 4'h0;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  // sizes
  localparam int ELEM_W = 4;
  localparam int ENTRIES = 16;
  localparam int COLOURS = 3;
  // colour element positions inside one entry
  localparam logic [1:0] ELEM_RED = 2'h0;
  localparam logic [1:0] ELEM_GREEN = 2'h1;
  localparam logic [1:0] ELEM_BLUE = 2'h2;
  // pixel depth encoding in the configuration register
  typedef enum logic [1:0] {
    BPP1 = 2'b00,
    BPP2 = 2'b01,
    BPP4 = 2'b10,
    BPP8 = 2'b11
  } ppl_bpp_type;
  // component select encoding
  typedef enum logic [1:0] {
    CSEL_AUTO = 2'b00,
    CSEL_RED = 2'b01,
    CSEL_GREEN = 2'b10,
    CSEL_BLUE = 2'b11
  } ppl_csel_type;
endpackage
`default_nettype wire

// >>> logic/ppl_unpack.sv
// splits packed display bytes into a stream of pixel codes
`default_nettype none
module ppl_unpack (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [1:0] mode_i,
  input wire logic [7:0] byte_i,
  input wire logic byte_valid_i,
  output logic byte_ready_o,
  output logic [7:0] pix_o,
  output logic pix_valid_o,
  input wire logic pix_ready_i
);
  logic [7:0] shift_r;
  logic [3:0] left_r;
  logic [1:0] mode_r;
  logic [3:0] per_byte;
  logic load;
  logic step;

  // pixels held by one byte at the requested depth
  always_comb begin
    case (mode_i)
      ppl_pkg::BPP1: per_byte = 4'h8;
      ppl_pkg::BPP2: per_byte = 4'h4;
      ppl_pkg::BPP4: per_byte = 4'h2;
      default: per_byte = 4'h1;
    endcase
  end

  // a new byte enters as the last pixel of the old one leaves
  assign pix_valid_o = (left_r != 4'h0);
  assign step = pix_valid_o && pix_ready_i;
  assign byte_ready_o = (left_r == 4'h0) || (left_r == 4'h1 && pix_ready_i);
  assign load = byte_valid_i && byte_ready_o;

  // leftmost pixel always sits in the top bits of shift_r
  always_comb begin
    case (mode_r)
      ppl_pkg::BPP1: pix_o = {7'h00, shift_r[7]}; // R1
      ppl_pkg::BPP2: pix_o = {6'h00, shift_r[7:6]}; // R3
      ppl_pkg::BPP4: pix_o = {4'h0, shift_r[7:4]}; // R5
      default: pix_o = shift_r; // R7
    endcase
  end

  // depth is latched per byte so a mid-byte change cannot tear it
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_r <= 8'h00;
      left_r <= 4'h0;
      mode_r <= ppl_pkg::BPP1;
    end else if (load) begin
      shift_r <= byte_i;
      left_r <= per_byte;
      mode_r <= mode_i;
    end else if (step) begin
      left_r <= left_r - 4'h1;
      case (mode_r)
        ppl_pkg::BPP1: shift_r <= {shift_r[6:0], 1'b0}; // R1
        ppl_pkg::BPP2: shift_r <= {shift_r[5:0], 2'b00}; // R3
        ppl_pkg::BPP4: shift_r <= {shift_r[3:0], 4'h0}; // R5
        default: shift_r <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> logic/ppl_bank.sv
// turns one pixel code and the bank choices into three entry indices
`default_nettype none
module ppl_bank (
  input wire logic [1:0] mode_i,
  input wire logic [7:0] pix_i,
  input wire logic [1:0] bank_red_i,
  input wire logic [1:0] bank_green_i,
  input wire logic [1:0] bank_blue_i,
  output logic [3:0] idx_red_o,
  output logic [3:0] idx_green_o,
  output logic [3:0] idx_blue_o
);
  // pure decode; the caller registers the looked-up colour
  always_comb begin
    case (mode_i)
      ppl_pkg::BPP1: begin
        // two-entry banks in the lower eight entries
        idx_red_o = {1'b0, bank_red_i, pix_i[0]}; // R19
        idx_green_o = {1'b0, bank_green_i, pix_i[0]}; // R19
        idx_blue_o = {1'b0, bank_blue_i, pix_i[0]}; // R2
      end
      ppl_pkg::BPP2: begin
        // each bank step moves the index by four
        idx_red_o = {bank_red_i, pix_i[1:0]}; // R20
        idx_green_o = {bank_green_i, pix_i[1:0]}; // R20
        idx_blue_o = {bank_blue_i, pix_i[1:0]}; // R4
      end
      ppl_pkg::BPP4: begin
        idx_red_o = pix_i[3:0]; // R21
        idx_green_o = pix_i[3:0]; // R21
        idx_blue_o = pix_i[3:0]; // R6
      end
      default: begin
        // only bank bit 0 matters for the two eight-entry banks
        idx_red_o = {bank_red_i[0], pix_i[7:5]}; // R22
        idx_green_o = {bank_green_i[0], pix_i[4:2]}; // R22
        idx_blue_o = {bank_blue_i, pix_i[1:0]}; // R22
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> verification/ppl_top_monitor.sv
// port checker for the palette lookup block
`default_nettype none
module ppl_top_monitor (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic pix_byte_valid_i,
  input wire logic pix_byte_ready_o,
  input wire logic [3:0] pix_red_o,
  input wire logic [3:0] pix_green_o,
  input wire logic [3:0] pix_blue_o,
  input wire logic pix_valid_o,
  input wire logic pix_ready_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // read data stands only in the cycle after a read strobe
  property p_rd_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_idx_top;
    reg_rd_i && reg_addr_i == ppl_pkg::ADDR_INDEX |=> reg_rdata_o[7:6] == 2'h0;
  endproperty
  a_idx_top: assert property (p_idx_top) else $error("index top bits");
  property p_bank_top;
    reg_rd_i && reg_addr_i == ppl_pkg::ADDR_BANK |=> reg_rdata_o[7:6] == 2'h0;
  endproperty
  a_bank_top: assert property (p_bank_top) else $error("bank top bits");
  property p_data_nib;
    reg_rd_i && reg_addr_i == ppl_pkg::ADDR_DATA |=> reg_rdata_o[7:4] == 4'h0;
  endproperty
  a_data_nib: assert property (p_data_nib) else $error("data nibble");
  // the bench's write then read leaves one idle cycle between strobes
  property p_idx_back;
    reg_wr_i && reg_addr_i == ppl_pkg::ADDR_INDEX ##2
      reg_rd_i && reg_addr_i == ppl_pkg::ADDR_INDEX
      |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h3f);
  endproperty
  a_idx_back: assert property (p_idx_back) else $error("index back");
  property p_bank_back;
    reg_wr_i && reg_addr_i == ppl_pkg::ADDR_BANK ##2
      reg_rd_i && reg_addr_i == ppl_pkg::ADDR_BANK
      |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h3f);
  endproperty
  a_bank_back: assert property (p_bank_back) else $error("bank back");
  property p_unmapped;
    reg_rd_i && reg_addr_i == 8'h30 |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  // a stalled pixel must not change, or the sink loses its place
  property p_pix_hold;
    pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_red_o) &&
      $stable(pix_green_o) && $stable(pix_blue_o);
  endproperty
  a_pix_hold: assert property (p_pix_hold) else $error("pixel changed");
  property p_pix_lat;
    pix_byte_valid_i && pix_byte_ready_o && !pix_valid_o
      |-> ##[1:2] pix_valid_o;
  endproperty
  a_pix_lat: assert property (p_pix_lat) else $error("pixel late");
endmodule
bind ppl_top ppl_top_monitor u_mon (.clock_i, .rstn_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pix_byte_valid_i,
  .pix_byte_ready_o, .pix_red_o, .pix_green_o, .pix_blue_o, .pix_valid_o,
  .pix_ready_i);
`default_nettype wire

// >>> verification/ppl_host.sv
// host model driving the register port of the palette block
`default_nettype none
module ppl_host (
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // elements are loaded only through the data register
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
    addr_o <= ~a; // released lines stop showing the last value
    wdata_o <= ~d;
  endtask
  // data is taken in the cycle after the strobe, settled at mid-cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(negedge clock_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// >>> verification/test_ppl_top.sv
// self-checking bench for the palette lookup block
`default_nettype none
module test_ppl_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, rstn_i, wr, rd, pvalid, pready, bready, ovalid;
  logic [7:0] addr, wdata, rdata, pbyte;
  logic [3:0] ored, ogreen, oblue;
  logic [3:0] pal [16][3];
  int errors, num_checks;
  ppl_host host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  ppl_top dut (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .pix_byte_i(pbyte), .pix_byte_valid_i(pvalid),
    .pix_byte_ready_o(bready), .pix_red_o(ored), .pix_green_o(ogreen),
    .pix_blue_o(oblue), .pix_valid_o(ovalid), .pix_ready_i(pready));
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    check("register", {4'h0, d}, {4'h0, e});
  endtask
  // reset values, unused bits and an unmapped place
  task automatic t_regs();
    rchk(ppl_pkg::ADDR_INDEX, 8'h00);
    rchk(ppl_pkg::ADDR_BANK, 8'h00);
    rchk(ppl_pkg::ADDR_DATA, 8'h00);
    host.wr(ppl_pkg::ADDR_INDEX, 8'hff);
    rchk(ppl_pkg::ADDR_INDEX, 8'h3f);
    host.wr(ppl_pkg::ADDR_BANK, 8'hff);
    rchk(ppl_pkg::ADDR_BANK, 8'h3f);
    rchk(8'h30, 8'h00);
  endtask
  // fill all entries in auto mode; the pointer wraps to zero
  task automatic t_load();
    host.wr(ppl_pkg::ADDR_INDEX, 8'h00);
    for (int e = 0; e < 16; e++) begin
      for (int c = 0; c < 3; c++) begin
        pal[e][c] = 4'(e + 5 * c + 1);
        host.wr(ppl_pkg::ADDR_DATA, {4'h0, pal[e][c]});
      end
    end
    rchk(ppl_pkg::ADDR_INDEX, 8'h00);
    host.wr(ppl_pkg::ADDR_INDEX, 8'h03);
    for (int c = 0; c < 3; c++) begin
      rchk(ppl_pkg::ADDR_DATA, {4'h0, pal[3][c]});
    end
    rchk(ppl_pkg::ADDR_INDEX, 8'h04);
  endtask
  // each single colour select touches one element and bumps the entry
  task automatic t_single();
    logic [1:0] s;
    for (int c = 1; c < 4; c++) begin
      s = 2'(c);
      host.wr(ppl_pkg::ADDR_INDEX, {2'h0, s, 4'h8});
      pal[8][c - 1] = 4'(c + 9);
      host.wr(ppl_pkg::ADDR_DATA, {4'h0, pal[8][c - 1]});
      rchk(ppl_pkg::ADDR_INDEX, {2'h0, s, 4'h9});
      host.wr(ppl_pkg::ADDR_INDEX, {2'h0, s, 4'h8});
      rchk(ppl_pkg::ADDR_DATA, {4'h0, pal[8][c - 1]});
    end
    host.wr(ppl_pkg::ADDR_INDEX, 8'h08);
    for (int c = 0; c < 3; c++) begin
      rchk(ppl_pkg::ADDR_DATA, {4'h0, pal[8][c]});
    end
  endtask
  // monochrome writes copy into all three elements
  task automatic t_mono();
    host.wr(ppl_pkg::ADDR_CONFIG, 8'h04);
    host.wr(ppl_pkg::ADDR_INDEX, 8'h02);
    for (int k = 0; k < 3; k++) host.wr(ppl_pkg::ADDR_DATA, 8'(k + 10));
    for (int c = 0; c < 3; c++) pal[2][c] = 4'hc;
    rchk(ppl_pkg::ADDR_INDEX, 8'h03);
    host.wr(ppl_pkg::ADDR_INDEX, 8'h02);
    for (int c = 0; c < 3; c++) rchk(ppl_pkg::ADDR_DATA, 8'h0c);
    rchk(ppl_pkg::ADDR_INDEX, 8'h03);
    host.wr(ppl_pkg::ADDR_INDEX, 8'h26);
    host.wr(ppl_pkg::ADDR_DATA, 8'h09);
    for (int c = 0; c < 3; c++) pal[6][c] = 4'h9;
    rchk(ppl_pkg::ADDR_INDEX, 8'h27);
    host.wr(ppl_pkg::ADDR_INDEX, 8'h06);
    for (int c = 0; c < 3; c++) rchk(ppl_pkg::ADDR_DATA, 8'h09);
  endtask
  function automatic logic [3:0] ix(input int b, input logic [1:0] k,
                                    input logic [7:0] p);
    case (b)
      0: return {1'b0, k, p[0]};
      1: return {k, p[1:0]};
      default: return p[3:0];
    endcase
  endfunction
  // one byte per depth and panel kind, sink stalling every other cycle
  task automatic t_pix();
    logic [3:0] ir, ig, ib;
    logic [7:0] p;
    logic [11:0] e;
    logic take;
    int n, got;
    host.wr(ppl_pkg::ADDR_BANK, 8'h1b);
    for (int m = 0; m < 2; m++) begin
      for (int b = 0; b < 4; b++) begin
        host.wr(ppl_pkg::ADDR_CONFIG, 8'(m * 4 + b));
        n = 8 >> b;
        got = 0;
        @(posedge clock_i);
        pbyte <= 8'hb4;
        pvalid <= 1'b1;
        for (int t = 0; t < 64 && got < n; t++) begin
          @(negedge clock_i);
          take = pvalid && bready === 1'b1;
          // empty unpacker takes a byte; a loaded one refuses the next below 8 bpp, at 8 bpp its one pixel leaves and it takes the next
          if (t < 2) check("ready", 12'(bready), 12'(t == 0 || n == 1));
          if (ovalid === 1'b1 && pready) begin
            p = 8'(8'hb4 >> (8 - (1 << b) * (got + 1)));
            // red bank 01 picks the upper eight-entry bank at 8 bpp
            ir = (b == 3) ? {1'b1, p[7:5]} : ix(b, 2'h1, p);
            ig = (b == 3) ? {1'b0, p[4:2]} : ix(b, 2'h2, p);
            ib = (b == 3) ? {2'h3, p[1:0]} : ix(b, 2'h3, p);
            e = {pal[ir][0], pal[ig][1], pal[ib][2]};
            if (m == 1) e = {3{pal[ig][1]}};
            check("pixel", {ored, ogreen, oblue}, e);
            got++;
          end
          @(posedge clock_i);
          if (take) begin
            pvalid <= 1'b0;
            pbyte <= 8'h4b;
          end
          pready <= ~pready;
        end
        if (got < n) begin
          check("pixel count", 12'(got), 12'(n));
          tally_and_finish();
        end
      end
    end
  endtask
  initial begin
    errors = 0;
    num_checks = 0;
    rstn_i = 1'b0;
    pbyte = 8'h00;
    pvalid = 1'b0;
    pready = 1'b0;
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    t_regs();
    t_load();
    t_single();
    t_mono();
    t_pix();
    tally_and_finish();
  end
endmodule
`default_nettype wire
